// >>> rtl/lmpl_pkg.sv
/*
  Shared constants and carriers of the line maintenance block: register
  offsets, field layouts, reset values, alarm counts and pattern figures.
  Assumes a 200 MHz master clock and a 32-bit APB register port.
*/
package lmpl_pkg;

  // Register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;   // Control word
  localparam logic [7:0] REG_STAT = 8'h04;   // Status word
  localparam logic [7:0] REG_ERRC = 8'h08;   // Error counter, clears on read

  // Control fields, bit 0 upward is lineStandardSelect
  typedef struct packed {
    logic [1:0] errSourceSelect;          // 19:18
    logic [4:0] signalLossThresholdCode;  // 17:13
    logic       equalizerEnable;          // 12
    logic       cdrEnable;                // 11
    logic       remoteLoopEnable;         // 10
    logic       digitalLoopEnable;        // 9
    logic       analogLoopEnable;         // 8
    logic       patternLockIrqMask;       // 7
    logic       patternLockEdgeSelect;    // 6
    logic       patternInvert;            // 5
    logic [1:0] patternSelect;            // 4:3
    logic       patternClockSelect;       // 2
    logic       alarmCriterionSelect;     // 1
    logic       lineStandardSelect;       // 0, 1 = T1/J1
  } lmpl_cfg_t;

  // Status fields
  typedef struct packed {
    logic patternLockEvent;        // 3, write one to clear
    logic patternLockStatus;       // 2
    logic alarmIndicationStatus;   // 1
    logic signalLoss;              // 0
  } lmpl_stat_t;

  localparam int         CFG_W       = 20;
  localparam lmpl_cfg_t  CFG_RESET   = 20'h00800;   // Recovery on, rest off
  localparam logic [1:0] PAT_NORMAL  = 2'h0;
  localparam logic [1:0] PAT_ONES    = 2'h1;
  localparam logic [1:0] PAT_PRBS    = 2'h2;
  localparam logic [1:0] ERR_PRBS    = 2'h0;

  // Loss-of-signal figures, in bit intervals and dB below nominal
  localparam logic [13:0] LOS_N_T1A   = 14'h00af;   // 175
  localparam logic [13:0] LOS_N_T1B   = 14'h0608;   // 1544
  localparam logic [13:0] LOS_N_E1A   = 14'h0020;   // 32
  localparam logic [13:0] LOS_N_E1B   = 14'h0800;   // 2048
  localparam logic [13:0] LOS_M_T1    = 14'h0080;   // 128
  localparam logic [13:0] LOS_M_E1    = 14'h0020;   // 32
  localparam logic [13:0] LOS_ZRUN_T1 = 14'h0064;   // 100
  localparam logic [13:0] LOS_ZRUN_E1 = 14'h0010;   // 16
  localparam logic [6:0]  LOS_Q_BASE  = 7'h04;      // Code 0 is 4 dB down
  localparam logic [4:0]  LOS_Q_MAXC  = 5'h0a;      // Last legal code
  localparam logic [6:0]  LOS_HYST_DB = 7'h04;      // Clear hysteresis

  // Alarm indication figures
  localparam logic [13:0] AIS_BLK_E1  = 14'h0200;   // 512
  localparam logic [13:0] AIS_ZER_E1  = 14'h0003;
  localparam logic [13:0] AIS_BLK_T1  = 14'h2000;   // 8192
  localparam logic [13:0] AIS_ZER_T1  = 14'h0009;

  // Pattern monitor window
  localparam logic [6:0]  WIN_LEN     = 7'h40;      // 64 bits
  localparam logic [6:0]  WIN_ERRMAX  = 7'h06;

  // Master-clock pattern rate, rates in kHz
  localparam int MCLK_KHZ    = 200000;
  localparam int RATE_T1_KHZ = 1544;
  localparam int RATE_E1_KHZ = 2048;
  localparam logic [7:0] DIV_T1 = 8'(MCLK_KHZ / RATE_T1_KHZ);
  localparam logic [7:0] DIV_E1 = 8'(MCLK_KHZ / RATE_E1_KHZ);

endpackage

// >>> rtl/lmpl_line_maint.sv
/*
  Line maintenance logic: loss-of-signal and alarm indication detection,
  test pattern insertion and monitoring, loopback path selection, APB
  register slave. Assumes clock and data pins from outside run far slower
  than mclk and are sampled here; the level input is a quasi-static code.
*/
// What this block does
// - Threshold code sets level with equalizer on, 2 dB steps
// - T1 first criterion: 175 down, 128 up
// - T1 second criterion: 1544 down
// - E1 first criterion: 32 down, 32 up
// - E1 second criterion: 2048 down
// - Alarm detection only with recovery enabled
// - E1 alarm: two 512-bit blocks, zeros
// - T1 alarm: 8192-bit span, 9 zeros
// - Pattern clock: transmit clock or master
// - Select 00, clock 0: pass data
// - Select 01 sends all ones
// - Select 00, clock 1: all zeros
// - Select 10 sends pattern, optional invert
// - T1 20-stage, E1 15-stage sequence
// - Lock: at most 6 errors in 64
// - Lock changes latched, edge selectable
// - Interrupt when event and mask set
// - Source 00 counts pattern bit errors
// - Analog loop returns transmit to receive
// - Digital loop returns transmit data
// - Patterns override transmit during local loops
// - Remote loop returns recovered data
// - Criteria picked by standard and criterion
`timescale 1ns/1ps
module lmpl_line_maint #(
  parameter int LEVEL_W      = 6,             // Width of level code, dB down
  parameter int LOS_FIXED_DB = 20             // Threshold with equalizer off
) (
  input  wire logic               mclk,            // Master clock
  input  wire logic               rst,             // Synchronous reset
  input  wire logic [7:0]         paddr,           // APB address
  input  wire logic               psel,            // APB select
  input  wire logic               penable,         // APB enable
  input  wire logic               pwrite,          // APB direction
  input  wire logic [31:0]        pwdata,          // APB write data
  output logic      [31:0]        prdata,          // APB read data
  output logic                    pready,          // APB ready
  output logic                    pslverr,         // APB error
  input  wire logic               transmitClockIn, // System transmit clock
  input  wire logic               txSysData,       // System transmit data
  input  wire logic               recClockIn,      // Recovered line clock
  input  wire logic               recDataIn,       // Recovered line data
  input  wire logic [LEVEL_W-1:0] rxLevelDb,       // Receive level, dB down
  output logic                    lineTxData,      // Data to line shaper
  output logic                    lineTxStrobe,    // Line bit strobe
  output logic                    rxOutData,       // Data to receive outputs
  output logic                    rxOutStrobe,     // Receive bit strobe
  output logic                    signalLossOut,   // Loss-of-signal level
  output logic                    patternLockIrq   // Lock event interrupt
);

  // Pick declare count from standard and criterion
  function automatic logic [13:0] losDeclareN(input logic t1, input logic alarm_criterion_select);
    if (t1) begin
      losDeclareN = alarm_criterion_select ? lmpl_pkg::LOS_N_T1B : lmpl_pkg::LOS_N_T1A;
    end else begin
      losDeclareN = alarm_criterion_select ? lmpl_pkg::LOS_N_E1B : lmpl_pkg::LOS_N_E1A;
    end
  endfunction

  // Feedback tap of the sequence register
  function automatic logic prbsFb(input logic [19:0] r, input logic t1);
    prbsFb = t1 ? (r[19] ^ r[16]) : (r[14] ^ r[13]);
  endfunction

  // Pin synchronisers: stage one, stage two, edge history
  logic [3:0]         syncA_ff;
  logic [3:0]         syncB_ff;
  logic [1:0]         clkHist_ff;
  logic [LEVEL_W-1:0] lvlA_ff;
  logic [LEVEL_W-1:0] lvlB_ff;
  logic               txRise;     // Transmit clock rising
  logic               rxTick;     // Recovered clock rising
  logic               txBit;      // Synchronised transmit data
  logic               rxBit;      // Synchronised recovered data

  // Two flops per pin, then edge detection on stage two only
  always_ff @(posedge mclk) begin
    if (rst) begin
      syncA_ff   <= 4'h0;
      syncB_ff   <= 4'h0;
      clkHist_ff <= 2'h0;
      lvlA_ff    <= '0;
      lvlB_ff    <= '0;
    end else begin
      syncA_ff   <= {recDataIn, recClockIn, txSysData, transmitClockIn};
      syncB_ff   <= syncA_ff;
      clkHist_ff <= {syncB_ff[2], syncB_ff[0]};
      lvlA_ff    <= rxLevelDb;
      lvlB_ff    <= lvlA_ff;
    end
  end

  assign txRise = syncB_ff[0] & ~clkHist_ff[0];
  assign rxTick = syncB_ff[2] & ~clkHist_ff[1];
  assign txBit  = syncB_ff[1];
  assign rxBit  = syncB_ff[3];

  // Register file state
  lmpl_pkg::lmpl_cfg_t cfg_ff,     nxt_cfg;
  logic [31:0]         rdata_ff,   nxt_rdata;
  logic                lockEvt_ff, nxt_lockEvt;
  logic [15:0]         errCnt_ff,  nxt_errCnt;
  logic                setup;      // APB setup phase
  logic                access;     // APB access phase
  logic                mapped;     // Address hits a register
  logic                lockRise;   // Lock status rose this cycle
  logic                lockFall;   // Lock status fell this cycle
  logic                countErr;   // Pattern error to count
  lmpl_pkg::lmpl_stat_t stat;

  assign setup   = psel & ~penable;
  assign access  = psel & penable;
  assign mapped  = (paddr == lmpl_pkg::REG_CTRL) || (paddr == lmpl_pkg::REG_STAT) ||
                   (paddr == lmpl_pkg::REG_ERRC);
  assign pready  = 1'b1;                         // No wait states
  assign pslverr = access & ~mapped;             // Unmapped address
  assign prdata  = rdata_ff;

  // Bus decode, event latch and error counter
  always_comb begin
    nxt_cfg     = cfg_ff;
    nxt_rdata   = rdata_ff;
    nxt_lockEvt = lockEvt_ff;
    nxt_errCnt  = errCnt_ff;
    // Read data captured in setup, stable through access
    if (setup) begin
      unique case (paddr)
        lmpl_pkg::REG_CTRL: nxt_rdata = {12'h000, cfg_ff};
        lmpl_pkg::REG_STAT: nxt_rdata = {28'h0000000, stat};
        lmpl_pkg::REG_ERRC: nxt_rdata = {16'h0000, errCnt_ff};
        default:            nxt_rdata = 32'h00000000;
      endcase
    end
    // Writes take effect at the access edge
    if (access && pwrite && paddr == lmpl_pkg::REG_CTRL) begin
      nxt_cfg = lmpl_pkg::lmpl_cfg_t'(pwdata[lmpl_pkg::CFG_W-1:0]);
    end
    if (access && pwrite && paddr == lmpl_pkg::REG_STAT && pwdata[3]) begin
      nxt_lockEvt = 1'b0;                        // Write one clears event
    end
    // Lock change capture wins over the clear
    if (lockRise || (lockFall && cfg_ff.patternLockEdgeSelect)) begin
      nxt_lockEvt = 1'b1;
    end
    // Reading the counter empties it
    if (access && !pwrite && paddr == lmpl_pkg::REG_ERRC) begin
      nxt_errCnt = 16'h0000;
    end
    // Count pattern errors, saturating; a new error outranks the read clear
    if (countErr) begin
      nxt_errCnt = (nxt_errCnt == 16'hffff) ? nxt_errCnt : nxt_errCnt + 16'h0001;
    end
  end

  // Register file flops
  always_ff @(posedge mclk) begin
    if (rst) begin
      cfg_ff     <= lmpl_pkg::CFG_RESET;
      rdata_ff   <= 32'h00000000;
      lockEvt_ff <= 1'b0;
      errCnt_ff  <= 16'h0000;
    end else begin
      cfg_ff     <= nxt_cfg;
      rdata_ff   <= nxt_rdata;
      lockEvt_ff <= nxt_lockEvt;
      errCnt_ff  <= nxt_errCnt;
    end
  end

  assign patternLockIrq = lockEvt_ff & cfg_ff.patternLockIrqMask;

  // Loss-of-signal state
  logic        los_ff,    nxt_los;
  logic [13:0] lowCnt_ff, nxt_lowCnt;   // Consecutive low intervals
  logic        inWin_ff,  nxt_inWin;    // Clear window running
  logic [13:0] winCnt_ff, nxt_winCnt;   // Intervals in clear window
  logic [13:0] ones_ff,   nxt_ones;     // Marks in clear window
  logic [13:0] zrun_ff,   nxt_zrun;     // Current zero run
  logic [6:0]  qDb;                     // Declare threshold, dB down
  logic        below;                   // Level under threshold
  logic        aboveH;                  // Level over threshold plus hysteresis
  logic [13:0] clrM;
  logic [13:0] zLim;
  logic [4:0]  qCode;

  // Threshold from code; reserved codes held at the last step
  always_comb begin
    qCode = (cfg_ff.signalLossThresholdCode > lmpl_pkg::LOS_Q_MAXC) ?
            lmpl_pkg::LOS_Q_MAXC : cfg_ff.signalLossThresholdCode;
    qDb   = cfg_ff.equalizerEnable ? lmpl_pkg::LOS_Q_BASE + {1'b0, qCode, 1'b0} :
            7'(LOS_FIXED_DB);
  end

  assign below  = 7'(lvlB_ff) > qDb;
  assign aboveH = (7'(lvlB_ff) + lmpl_pkg::LOS_HYST_DB) < qDb;
  assign clrM   = cfg_ff.lineStandardSelect ? lmpl_pkg::LOS_M_T1 : lmpl_pkg::LOS_M_E1;
  assign zLim   = cfg_ff.lineStandardSelect ? lmpl_pkg::LOS_ZRUN_T1 : lmpl_pkg::LOS_ZRUN_E1;

  // Declare on a low run, clear on a clean window opened by a mark
  always_comb begin
    nxt_los    = los_ff;
    nxt_lowCnt = lowCnt_ff;
    nxt_inWin  = inWin_ff;
    nxt_winCnt = winCnt_ff;
    nxt_ones   = ones_ff;
    nxt_zrun   = zrun_ff;
    if (rxTick && !los_ff) begin
      nxt_lowCnt = below ? lowCnt_ff + 14'h0001 : 14'h0000;
      if (below && nxt_lowCnt >= losDeclareN(cfg_ff.lineStandardSelect,
                                             cfg_ff.alarmCriterionSelect)) begin
        nxt_los   = 1'b1;
        nxt_inWin = 1'b0;
      end
    end else if (rxTick && !inWin_ff) begin
      // Window starts with the receipt of a pulse
      if (aboveH && rxBit) begin
        nxt_inWin  = 1'b1;
        nxt_winCnt = 14'h0001;
        nxt_ones   = 14'h0001;
        nxt_zrun   = 14'h0000;
      end
    end else if (rxTick) begin
      nxt_winCnt = winCnt_ff + 14'h0001;
      nxt_ones   = ones_ff + {13'h0000, rxBit};
      nxt_zrun   = rxBit ? 14'h0000 : zrun_ff + 14'h0001;
      if (!aboveH || nxt_zrun >= zLim) begin
        nxt_inWin = 1'b0;
      end else if (nxt_winCnt >= clrM) begin
        nxt_inWin = 1'b0;
        // At least one mark in eight
        if ({nxt_ones[10:0], 3'h0} >= clrM) begin
          nxt_los    = 1'b0;
          nxt_lowCnt = 14'h0000;
        end
      end
    end
  end

  // Loss-of-signal flops
  always_ff @(posedge mclk) begin
    if (rst) begin
      los_ff    <= 1'b0;
      lowCnt_ff <= 14'h0000;
      inWin_ff  <= 1'b0;
      winCnt_ff <= 14'h0000;
      ones_ff   <= 14'h0000;
      zrun_ff   <= 14'h0000;
    end else begin
      los_ff    <= nxt_los;
      lowCnt_ff <= nxt_lowCnt;
      inWin_ff  <= nxt_inWin;
      winCnt_ff <= nxt_winCnt;
      ones_ff   <= nxt_ones;
      zrun_ff   <= nxt_zrun;
    end
  end

  assign signalLossOut = los_ff;

  // Alarm indication state
  logic        ais_ff,     nxt_ais;
  logic [13:0] aisBlk_ff,  nxt_aisBlk;   // Bits in current block
  logic [13:0] aisZer_ff,  nxt_aisZer;   // Zeros in current block
  logic        prevLow_ff, nxt_prevLow;  // Previous E1 block was low
  logic        lowBlk;

  // Count zeros per block, decide at each block end
  always_comb begin
    nxt_ais     = ais_ff;
    nxt_aisBlk  = aisBlk_ff;
    nxt_aisZer  = aisZer_ff;
    nxt_prevLow = prevLow_ff;
    lowBlk      = 1'b0;
    if (!cfg_ff.cdrEnable) begin
      // Detector idle without recovery
      nxt_ais     = 1'b0;
      nxt_aisBlk  = 14'h0000;
      nxt_aisZer  = 14'h0000;
      nxt_prevLow = 1'b0;
    end else if (rxTick) begin
      nxt_aisZer = aisZer_ff + {13'h0000, ~rxBit};
      nxt_aisBlk = aisBlk_ff + 14'h0001;
      // Block end also catches a count left past the length by a mode change
      if (cfg_ff.lineStandardSelect && nxt_aisBlk >= lmpl_pkg::AIS_BLK_T1) begin
        nxt_ais    = nxt_aisZer < lmpl_pkg::AIS_ZER_T1;
        nxt_aisBlk = 14'h0000;
        nxt_aisZer = 14'h0000;
      end else if (!cfg_ff.lineStandardSelect && nxt_aisBlk >= lmpl_pkg::AIS_BLK_E1) begin
        lowBlk = nxt_aisZer < lmpl_pkg::AIS_ZER_E1;
        // Two like blocks in a row change the state
        if (lowBlk && prevLow_ff) begin
          nxt_ais = 1'b1;
        end else if (!lowBlk && !prevLow_ff) begin
          nxt_ais = 1'b0;
        end
        nxt_prevLow = lowBlk;
        nxt_aisBlk  = 14'h0000;
        nxt_aisZer  = 14'h0000;
      end
    end
  end

  // Alarm indication flops
  always_ff @(posedge mclk) begin
    if (rst) begin
      ais_ff     <= 1'b0;
      aisBlk_ff  <= 14'h0000;
      aisZer_ff  <= 14'h0000;
      prevLow_ff <= 1'b0;
    end else begin
      ais_ff     <= nxt_ais;
      aisBlk_ff  <= nxt_aisBlk;
      aisZer_ff  <= nxt_aisZer;
      prevLow_ff <= nxt_prevLow;
    end
  end

  // Pattern path state
  logic [7:0]  div_ff,     nxt_div;      // Master-clock rate divider
  logic [19:0] gen_ff,     nxt_gen;      // Generator register
  logic [19:0] chk_ff,     nxt_chk;      // Checker register
  logic [63:0] errHist_ff, nxt_errHist;  // Error history window
  logic [6:0]  errWin_ff,  nxt_errWin;   // Errors inside window
  logic [6:0]  fill_ff,    nxt_fill;     // Bits seen since start
  logic        lock_ff,    nxt_lock;
  logic        txOut_ff,   nxt_txOut;
  logic        txStb_ff,   nxt_txStb;
  logic        rxOut_ff,   nxt_rxOut;
  logic        rxStb_ff,   nxt_rxStb;
  logic        mTick;                    // Master-clock bit enable
  logic        patTick;                  // Pattern bit enable
  logic        t1;
  logic        genBit;
  logic        patBit;
  logic        loopLocal;
  logic        chkStb;
  logic        chkBit;
  logic        expBit;
  logic        bitErr;

  assign t1        = cfg_ff.lineStandardSelect;
  assign mTick     = (div_ff == 8'h00);
  assign patTick   = cfg_ff.patternClockSelect ? mTick : txRise;
  assign loopLocal = cfg_ff.analogLoopEnable | cfg_ff.digitalLoopEnable;
  // Zero suppression in the 20-stage sequence
  assign genBit    = (t1 && gen_ff[13:0] == 14'h0000) ? 1'b1 : prbsFb(gen_ff, t1);
  // Receive side sees the looped stream during local loops
  assign chkStb    = loopLocal ? patTick : rxTick;
  assign chkBit    = loopLocal ? nxt_txOut : rxBit;
  assign expBit    = prbsFb(chk_ff, t1) ^ cfg_ff.patternInvert;
  assign bitErr    = chkStb & (chkBit ^ expBit);
  assign lockRise  = nxt_lock & ~lock_ff;
  assign lockFall  = ~nxt_lock & lock_ff;
  assign countErr  = bitErr & lock_ff & (cfg_ff.errSourceSelect == lmpl_pkg::ERR_PRBS);

  // Transmit selection, generator, loops and checker
  always_comb begin
    nxt_div     = mTick ? (t1 ? lmpl_pkg::DIV_T1 : lmpl_pkg::DIV_E1) - 8'h01 :
                  div_ff - 8'h01;
    nxt_gen     = gen_ff;
    nxt_chk     = chk_ff;
    nxt_errHist = errHist_ff;
    nxt_errWin  = errWin_ff;
    nxt_fill    = fill_ff;
    nxt_lock    = lock_ff;
    nxt_txStb   = 1'b0;
    nxt_txOut   = txOut_ff;
    nxt_rxStb   = 1'b0;
    nxt_rxOut   = rxOut_ff;
    // Data choice for the next line bit
    unique case (cfg_ff.patternSelect)
      lmpl_pkg::PAT_NORMAL: patBit = cfg_ff.patternClockSelect ? 1'b0 : txBit;
      lmpl_pkg::PAT_ONES:   patBit = 1'b1;
      lmpl_pkg::PAT_PRBS:   patBit = genBit ^ cfg_ff.patternInvert;
      default:              patBit = txBit;      // Loop code not built here
    endcase
    if (cfg_ff.remoteLoopEnable) begin
      // Recovered data back to the line
      if (rxTick) begin
        nxt_txOut = rxBit;
        nxt_txStb = 1'b1;
      end
    end else if (patTick) begin
      // Patterns overwrite transmit data in local loops too
      nxt_txOut = patBit;
      nxt_txStb = 1'b1;
    end
    if (patTick && cfg_ff.patternSelect == lmpl_pkg::PAT_PRBS) begin
      nxt_gen = {gen_ff[18:0], prbsFb(gen_ff, t1)};
    end
    // Receive outputs: looped transmit stream or recovered line data
    if (chkStb) begin
      nxt_rxOut = chkBit;
      nxt_rxStb = 1'b1;
    end
    // Self-synchronising checker and sliding error window
    if (chkStb) begin
      nxt_chk     = {chk_ff[18:0], chkBit ^ cfg_ff.patternInvert};
      nxt_errHist = {errHist_ff[62:0], bitErr};
      nxt_errWin  = errWin_ff + {6'h00, bitErr} - {6'h00, errHist_ff[63]};
      nxt_fill    = (fill_ff == lmpl_pkg::WIN_LEN) ? fill_ff : fill_ff + 7'h01;
      if (nxt_fill == lmpl_pkg::WIN_LEN) begin
        nxt_lock = nxt_errWin <= lmpl_pkg::WIN_ERRMAX;
      end
    end
  end

  // Pattern path flops
  always_ff @(posedge mclk) begin
    if (rst) begin
      div_ff     <= 8'h00;
      gen_ff     <= 20'hfffff;
      chk_ff     <= 20'h00000;
      errHist_ff <= 64'h0000000000000000;
      errWin_ff  <= 7'h00;
      fill_ff    <= 7'h00;
      lock_ff    <= 1'b0;
      txOut_ff   <= 1'b0;
      txStb_ff   <= 1'b0;
      rxOut_ff   <= 1'b0;
      rxStb_ff   <= 1'b0;
    end else begin
      div_ff     <= nxt_div;
      gen_ff     <= nxt_gen;
      chk_ff     <= nxt_chk;
      errHist_ff <= nxt_errHist;
      errWin_ff  <= nxt_errWin;
      fill_ff    <= nxt_fill;
      lock_ff    <= nxt_lock;
      txOut_ff   <= nxt_txOut;
      txStb_ff   <= nxt_txStb;
      rxOut_ff   <= nxt_rxOut;
      rxStb_ff   <= nxt_rxStb;
    end
  end

  assign lineTxData   = txOut_ff;
  assign lineTxStrobe = txStb_ff;
  assign rxOutData    = rxOut_ff;
  assign rxOutStrobe  = rxStb_ff;

  // Status word assembly
  always_comb begin
    stat.patternLockEvent      = lockEvt_ff;
    stat.patternLockStatus     = lock_ff;
    stat.alarmIndicationStatus = ais_ff;
    stat.signalLoss            = los_ff;
  end

endmodule

// >>> test/lmpl_line_maint_props.sv
/* Checker of the line maintenance block, bound to its ports.
   Assumes CTRL changes only by APB writes to offset 0x00. */
`timescale 1ns/1ps
module lmpl_line_maint_props (
  input wire logic        mclk, rst, psel, penable, pwrite, pready, pslverr,
  input wire logic        txSysData, recDataIn, lineTxData, lineTxStrobe,
  input wire logic        rxOutData, rxOutStrobe, patternLockIrq,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata, prdata
);
  logic [19:0] ctrl_ff;   // Mirror of the control word
  logic [3:0]  quiet_ff;  // Cycles since the last control write
  wire       cfgOk = quiet_ff == 4'hf;              // Old settings flushed
  wire       st    = lineTxStrobe && cfgOk && !ctrl_ff[10];
  wire [1:0] ps    = ctrl_ff[4:3];
  // Follow control writes at the access edge
  always_ff @(posedge mclk) begin
    if (rst) begin
      ctrl_ff <= 20'h00800;
      quiet_ff <= 4'h0;
    end else if (psel && penable && pwrite && paddr == 8'h00) begin
      ctrl_ff <= pwdata[19:0];
      quiet_ff <= 4'h0;
    end else if (!cfgOk) begin
      quiet_ff <= quiet_ff + 4'h1;
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  property p_bus; psel && penable |-> pready && pslverr == !(paddr inside {8'h00, 8'h04, 8'h08});
  endproperty
  a_bus: assert property (p_bus) else $error("bus answer wrong");
  property p_pulse; lineTxStrobe |=> (!lineTxStrobe || !cfgOk) [*8]; endproperty
  a_pulse: assert property (p_pulse) else $error("line strobe too long");
  property p_ones; st && ps == 2'h1 |-> lineTxData; endproperty
  a_ones: assert property (p_ones) else $error("all ones broken");
  property p_zero; st && ps == 2'h0 && ctrl_ff[2] |-> !lineTxData; endproperty
  a_zero: assert property (p_zero) else $error("all zeros broken");
  property p_pass; st && ps == 2'h0 && !ctrl_ff[2] |-> lineTxData == $past(txSysData, 4);
  endproperty
  a_pass: assert property (p_pass) else $error("pass data broken");
  property p_loop; st && ctrl_ff[9:8] != 2'h0 |-> ##[0:2] rxOutStrobe && rxOutData == lineTxData;
  endproperty
  a_loop: assert property (p_loop) else $error("local loop broken");
  property p_remote; lineTxStrobe && cfgOk && ctrl_ff[10] |-> lineTxData == $past(recDataIn, 4);
  endproperty
  a_remote: assert property (p_remote) else $error("remote loop broken");
  property p_cdr; psel && penable && paddr == 8'h04 && cfgOk && !ctrl_ff[11] |-> !prdata[1];
  endproperty
  a_cdr: assert property (p_cdr) else $error("alarm without recovery");
  property p_irq; patternLockIrq |-> ctrl_ff[7]; endproperty
  a_irq: assert property (p_irq) else $error("interrupt while masked");
  cover property (patternLockIrq);
  cover property (st && ps == 2'h2);
  cover property (lineTxStrobe && ctrl_ff[10]);
endmodule
bind lmpl_line_maint lmpl_line_maint_props lmpl_line_maint_props_inst (.*);

// >>> test/lmpl_framer_model.sv
/* Framer model on the system side: transmit clock while run is high,
   byte pattern MSB first. Assumes the bench holds run during frames. */
`timescale 1ns/1ps
module lmpl_framer_model (
  input  wire logic       run,
  input  wire logic [7:0] pat,
  output logic            txClk,
  output logic            txData
);
  int bitNo = 0;  // Bit within the byte
  // Clock idles low outside frames, data moves after the falling edge
  initial begin
    txClk = 1'b0;
    txData = 1'b1;
    #1.3;
    forever begin
      #80 txClk = run;
      #80 txClk = 1'b0;
      txData = pat[7 - bitNo];
      bitNo = (bitNo + 1) % 8;
    end
  end
endmodule

// >>> test/tb_lmpl_line_maint.sv
/* Bench of the line maintenance block: APB tasks, framer model, and the
   line looped back to the recovered input through a cable stub. */
`timescale 1ns/1ps
module tb_lmpl_line_maint;
  logic        mclk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, run = 0;
  logic [7:0]  paddr = '0, pat = 8'hff;
  logic [31:0] pwdata = '0, prdata, rd;
  logic        pready, pslverr, txClk, txData, lineTxData, lineTxStrobe;
  logic        rxOutData, rxOutStrobe, signalLossOut, patternLockIrq;
  logic [5:0]  level = '0;
  logic [1:0]  cab = 2'h2;  // Cable: 0 loop, 1 zeros, 2 ones
  int          fails = 0, comparisons = 0, cyc = 0;
  logic [23:0] tc [8] = '{24'h800ff1, 24'h800000, 24'h808001, 24'h80c001,
                          24'h804ff0, 24'ha08001, 24'h908001, 24'hc04001};
  wire recData = cab == 2'h0 ? lineTxData : cab == 2'h2;
  lmpl_line_maint lmpl_line_maint_inst (.mclk, .rst, .paddr, .psel, .penable, .pwrite,
    .pwdata, .prdata, .pready, .pslverr, .transmitClockIn(txClk), .txSysData(txData),
    .recClockIn(txClk), .recDataIn(recData), .rxLevelDb(level), .lineTxData,
    .lineTxStrobe, .rxOutData, .rxOutStrobe, .signalLossOut, .patternLockIrq);
  lmpl_framer_model lmpl_framer_model_inst (.run, .pat, .txClk, .txData);
  initial forever #2.5 mclk = ~mclk;
  // Hang guard
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 90000) begin
      fails++;
      close_out();
    end
  end
  task automatic close_out;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      fails++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  // One APB transfer, held until pready
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    psel <= 1'b1;
    @(posedge mclk) penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic rdchk(input string n, input logic [7:0] a, input logic [31:0] m, e);
    xfer(1'b0, a, '0);
    chk(n, rd & m, e);
  endtask
  task automatic bits(input int n);
    repeat (n) @(posedge txClk);
    @(posedge mclk);
  endtask
  initial begin
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    run <= 1'b1;
    @(posedge mclk);
    rdchk("ctrl", 8'h00, '1, 32'h800);
    xfer(1'b1, 8'h00, '1);
    rdchk("ctrlw", 8'h00, '1, 32'hfffff);
    rdchk("hole", 8'h0c, '1, '0);
    $display("registers done");
    foreach (tc[i]) begin
      pat <= tc[i][11:4];
      xfer(1'b1, 8'h00, 32'(tc[i][23:12]));
      repeat (3) @(posedge lineTxStrobe);
      @(posedge mclk);
      chk("line", 32'(lineTxData), 32'(tc[i][0]));
    end
    $display("patterns done");
    cab <= 2'h0;
    xfer(1'b1, 8'h00, 32'h890);
    bits(100);
    rdchk("lock", 8'h04, 32'hc, 32'hc);
    chk("irq", 32'(patternLockIrq), 32'h1);
    rdchk("errc", 8'h08, '1, '0);
    xfer(1'b1, 8'h04, 32'h8);
    cab <= 2'h2;
    bits(100);
    rdchk("unlock", 8'h04, 32'hc, '0);
    xfer(1'b0, 8'h08, '0);
    chk("errs", 32'(rd[15:0] == 16'h0), '0);
    xfer(1'b1, 8'h00, 32'h8d0);
    cab <= 2'h0;
    bits(100);
    xfer(1'b1, 8'h04, 32'h8);
    cab <= 2'h2;
    bits(100);
    rdchk("anyedge", 8'h04, 32'hc, 32'h8);
    $display("monitor done");
    cab <= 2'h2;
    xfer(1'b1, 8'h00, 32'h7800);
    level <= 6'h0a;
    bits(40);
    chk("losq", 32'(signalLossOut), '0);
    level <= 6'h0b;
    bits(20);
    chk("los20", 32'(signalLossOut), '0);
    bits(20);
    chk("los40", 32'(signalLossOut), 32'h1);
    level <= 6'h05;
    bits(45);
    chk("losclr", 32'(signalLossOut), '0);
    xfer(1'b1, 8'h00, 32'h7801);
    level <= 6'h0b;
    bits(150);
    chk("t1los150", 32'(signalLossOut), '0);
    bits(40);
    chk("t1los190", 32'(signalLossOut), 32'h1);
    $display("signal loss done");
    level <= 6'h00;
    xfer(1'b1, 8'h00, 32'h800);
    bits(1100);
    rdchk("ais", 8'h04, 32'h2, 32'h2);
    xfer(1'b1, 8'h00, 32'h0);
    bits(2);
    rdchk("aisoff", 8'h04, 32'h2, '0);
    $display("alarm done");
    close_out();
  end
endmodule
